// >>> bench/dram_model.sv
`timescale 1ns/1ps
// DRAM stand-in: decodes commands on the rising command clock and answers readout reads
module dram_model #(
  parameter int         rl      = 16,
  parameter logic [2:0] par_lat = 3'h5
) (
  input  wire logic                        ck,
  input  wire dram_readout_pkg::cmd_pins_t pins,
  input  wire logic                        bc4,
  input  wire logic [1:0]                  temp_in,
  output logic      [3:0]                  dq,
  output logic                             dqs
);
  logic       mode;
  logic       temp_en;
  logic [1:0] page;
  logic [1:0] temp_st;
  logic [7:0] b;
  logic [2:0] s;
  // Serial burst after the read latency, one preamble clock first
  task burst(input logic [1:0] loc, input logic upper);
    int i;
    begin
      b = page == 2'h0 ? 8'(32'h000F3355 >> {loc, 3'h0}) :
          page == 2'h1 ? {5'h00, par_lat} :
          page == 2'h2 ? {3'h0, temp_st, 3'h0} : 8'h0A;
      s = upper ? 3'h3 : 3'h7;
      repeat (rl - 1) @(posedge ck);
      dqs = 1'b0;
      @(posedge ck);
      for (i = 0; i < (bc4 ? 4 : 8); i++) begin
        dq = {4{b[s]}};
        dqs = ~dqs;
        s = s - 3'h1;
        @(ck);
      end
      dqs = 1'b1;
    end
  endtask
  // Idle lanes change every clock so stale data is never mistaken for a burst
  initial begin
    dqs = 1'b1;
    dq = 4'h0;
    mode = 1'b0;
    temp_en = 1'b0;
    temp_st = 2'h1;
    page = 2'h0;
    forever begin
      @(posedge ck);
      dq = ~dq;
      if (temp_en) temp_st = temp_in;
      if (!pins.cs_n && pins.code == dram_readout_pkg::CMD_MRS && pins.ba == 2'h3) begin
        mode = pins.addr[2];
        page = pins.addr[1:0];
        temp_en = pins.addr[5];
      end else if (mode && !pins.cs_n && pins.code == dram_readout_pkg::CMD_RD) burst(pins.ba, pins.addr[2]);
    end
  end
endmodule

// >>> bench/tb.sv
`timescale 1ns/1ps
module tb;
  logic                        mclk, rst, psel, penable, pwrite, pready, pslverr, ck, dqs, bc4, e, p, dl;
  logic [7:0]                  paddr;
  logic [31:0]                 pwdata, prdata, r;
  logic [3:0]                  dq;
  logic [1:0]                  t, t0, lc;
  dram_readout_pkg::cmd_pins_t pins;
  int                          failures, check_count, i, k;
  // Controller and its DRAM
  dram_readout_host DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dq(dq), .dqs(dqs), .dll_lock(dl),
    .ck(ck), .pins(pins));
  dram_model PEER (.ck(ck), .pins(pins), .bc4(bc4), .temp_in(t), .dq(dq), .dqs(dqs));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task conclude;
    begin
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    begin
      check_count++;
      if (g !== x) begin
        failures++;
        $display("[ERR] %s expected %h seen %h", n, x, g);
      end
    end
  endtask
  // One APB transfer, held until pready; answer left in r and e
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge mclk);
        n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
        $display("[ERR] pready expected 1 seen %b", pready);
        failures++;
        conclude;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
    end
  endtask
  // Starts an operation and polls until nothing is pending or busy; STAT left in r
  task op(input logic [1:0] c);
    int n;
    begin
      apb(1'b1, dram_readout_pkg::CTRL_OFS, {29'h0, c, 1'b1});
      n = 0;
      do begin
        apb(1'b0, dram_readout_pkg::CTRL_OFS, 32'h0);
        p = r[0];
        apb(1'b0, dram_readout_pkg::STAT_OFS, 32'h0);
        n++;
        if (n > 3000) begin
          $display("[ERR] op_idle expected 0 seen %b", p);
          failures++;
          conclude;
        end
      end while (p !== 1'b0 || r[0] !== 1'b0);
    end
  endtask
  task cfg(input logic [1:0] pg, l, input logic b, nb, te, input logic [1:0] f);
    begin
      bc4 <= b;
      apb(1'b1, dram_readout_pkg::CFG_OFS, {22'h0, ~b, te, nb, b, f, l, pg} | 32'h8000);
    end
  endtask
  task rd(input logic [31:0] x);
    begin
      op(dram_readout_pkg::OP_READ);
      chk("rd_stat", 32'h6, r & 32'h3E);
      apb(1'b0, dram_readout_pkg::DATA_OFS, 32'h0);
      chk("data", x, r);
    end
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bc4 = 1'b0;
    dl = 1'b1;
    t = 2'h1;
    failures = 0;
    check_count = 0;
    void'($urandom(13685));
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    apb(1'b0, dram_readout_pkg::CFG_OFS, 32'h0);
    chk("cfg_reset", dram_readout_pkg::CFG_RESET, r);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    op(dram_readout_pkg::OP_READ);
    chk("idle_read", 32'h10, r & 32'h12);
    $display("test registers done");
    k = $urandom % 4;
    cfg(2'h0, 2'h0, 1'b0, 1'b0, 1'b1, dram_readout_pkg::FMT_SERIAL);
    op(dram_readout_pkg::OP_ENTER);
    chk("mode", 32'h2, r & 32'h1A);
    for (i = 0; i < 6; i++) begin
      lc = i < 4 ? 2'(i + k) : 2'h0;
      cfg(2'h0, lc, i > 3, i[0], 1'b1, dram_readout_pkg::FMT_SERIAL);
      rd((32'h000F3355 >> {lc, 3'h0}) & (i < 4 ? 32'hFF : i == 4 ? 32'hF0 : 32'h0F));
    end
    op(dram_readout_pkg::OP_EXIT);
    chk("exit", 32'h0, r & 32'h2);
    $display("test page zero done");
    t0 = 2'($urandom % 3);
    t <= t0;
    cfg(2'h1, 2'h3, 1'b0, 1'b0, 1'b1, 2'h2);
    op(dram_readout_pkg::OP_ENTER);
    rd({29'h0, 3'h5});
    op(dram_readout_pkg::OP_EXIT);
    cfg(2'h2, 2'h0, 1'b0, 1'b0, 1'b1, dram_readout_pkg::FMT_SERIAL);
    op(dram_readout_pkg::OP_ENTER);
    rd({27'h0, t0, 3'h0});
    op(dram_readout_pkg::OP_EXIT);
    cfg(2'h2, 2'h0, 1'b0, 1'b0, 1'b0, dram_readout_pkg::FMT_SERIAL);
    op(dram_readout_pkg::OP_ENTER);
    t <= 2'h3 - t0;
    rd({27'h0, t0, 3'h0});
    op(dram_readout_pkg::OP_EXIT);
    $display("test pages done");
    dl <= 1'b0;
    apb(1'b1, dram_readout_pkg::CFG_OFS, 32'h8400);
    apb(1'b1, dram_readout_pkg::CTRL_OFS, 32'h1);
    repeat (40) @(posedge mclk);
    apb(1'b0, dram_readout_pkg::CTRL_OFS, 32'h0);
    chk("dll_wait", 32'h1, r);
    dl <= 1'b1;
    op(dram_readout_pkg::OP_ENTER);
    chk("dll_go", 32'h12, r & 32'h12);
    op(dram_readout_pkg::OP_EXIT);
    cfg(2'h0, 2'h0, 1'b0, 1'b0, 1'b0, dram_readout_pkg::FMT_RSVD);
    op(dram_readout_pkg::OP_ENTER);
    chk("fmt_rsvd", 32'h10, r & 32'h12);
    $display("test format done");
    conclude;
  end
endmodule

// >>> rtl/dram_readout_host.sv
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
// Functional notes
// [RULE_01] Device refreshes temperature status in page 2 location 0 every 32ms when enabled.
// [RULE_02] Device freezes temperature status when the update enable bit is clear.
// [RULE_03] Temperature status: 00 slow, 01 nominal, 10 double rate, 11 reserved.
// [RULE_04] Page 1 location 3 low bits show the latest parity latency.
// [RULE_05] Readout reads use fixed BL8 or BC4 only, never on-the-fly chop.
// [RULE_06] Device ignores read bus inversion while in readout mode.
// [RULE_07] BC4 readout reads start only at column 000 or 100.
// [RULE_08] Page 0 holds default patterns until rewritten; written values persist.
// [RULE_09] Page 0 back-to-back reads may use short or long column spacing.
// [RULE_10] Pages 1 to 3 back-to-back reads use the long column spacing.
// [RULE_11] Before entry: DLL locked, precharge all, wait precharge time, set enable.
// [RULE_12] Format field: 00 serial, 01 parallel, 10 staggered, 11 reserved.
// [RULE_13] Two low mode bits choose page 0 to 3.
// [RULE_14] Bank address bits of each read choose location 0 to 3.
// [RULE_15] BL8 with on-the-fly burst field set drives chop select high.
// [RULE_16] Column bit 2 picks burst order; BL8 needs 0, BC4 picks nibble.
// [RULE_17] Column bits 1:0 are 00; other address bits are don't care.
// [RULE_18] Burst arrives after additive plus CAS latency from the read.
// [RULE_19] After last burst wait recovery, clear enable, wait mode delay.
// [RULE_20] Serial format for pages 1 to 3; page 0 may use any format.
// [RULE_21] Device drives strobes with readout data, preamble as programmed.
// [RULE_22] Serial format puts the identical bit sequence on every lane.
// [RULE_23] Serial readout sends bit 7 first and bit 0 last.
// [RULE_24] After the enabling write wait both mode delays before the first read.
module dram_readout_host (
  input  wire logic                         mclk,
  input  wire logic                         rst,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [7:0]                   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [3:0]                   dq,
  input  wire logic                         dqs,
  input  wire logic                         dll_lock,
  output logic                              ck,
  output dram_readout_pkg::cmd_pins_t       pins
);

  dram_readout_pkg::state_t state;
  dram_readout_pkg::state_t ret_state;
  dram_readout_pkg::cmd_pins_t next_pins;
  logic [5:0]  raw;
  logic [5:0]  s1;
  logic [5:0]  s2;
  logic [5:0]  s3;
  logic [5:0]  clean;
  logic [1:0]  div_cnt;
  logic [31:0] cfg;
  logic [5:0]  wait_cnt;
  logic [5:0]  ccd_cnt;
  logic [5:0]  mprr_cnt;
  logic        go_pend;
  logic [1:0]  go_op;
  logic        mode;
  logic        done;
  logic        refused;
  logic        timeout;
  logic        mismatch;
  logic        dqs_prev;
  logic        armed;
  logic [3:0]  beat;
  logic        smp_pend;
  logic [1:0]  smp_cnt;
  logic [5:0]  cap_ticks;
  logic        cap_end;
  logic        cap_done;
  logic        cap_to;
  logic        cap_mis;
  logic [7:0]  rd_byte;

  // Input synchronisers: three stages, a change counts once stages two and three agree
  assign raw = {dll_lock, dqs, dq};
  for (genvar i = 0; i < 6; i++) begin : g_sync
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        s1[i]    <= 1'b0;
        s2[i]    <= 1'b0;
        s3[i]    <= 1'b0;
        clean[i] <= 1'b0;
      end else begin
        s1[i] <= raw[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
        if (s2[i] == s3[i]) begin
          clean[i] <= s3[i];
        end
      end
    end
  end

  // Decoded fields, ticks and bus strobes
  wire [3:0] dq_s       = clean[3:0];
  wire       dqs_s      = clean[4];
  wire       dll_s      = clean[5];
  wire       dqs_edge   = dqs_s ^ dqs_prev;
  wire       div_wrap   = div_cnt == dram_readout_pkg::DIV_LAST;
  wire       fall_tick  = div_wrap & ck;
  wire [1:0] page       = cfg[dram_readout_pkg::CFG_PAGE_LSB +: 2];
  wire [1:0] loc        = cfg[dram_readout_pkg::CFG_LOC_LSB +: 2];
  wire [1:0] fmt_req    = cfg[dram_readout_pkg::CFG_FMT_LSB +: 2];
  wire       bc4        = cfg[dram_readout_pkg::CFG_BC4_BIT];
  wire       nib        = cfg[dram_readout_pkg::CFG_NIB_BIT] & bc4;                        // RULE_16
  wire       temp_en    = cfg[dram_readout_pkg::CFG_TEMP_BIT];
  wire       otf        = cfg[dram_readout_pkg::CFG_OTF_BIT];
  wire       dll_hold   = cfg[dram_readout_pkg::CFG_DLL_BIT] & ~dll_s;                     // RULE_11
  wire [5:0] rl         = cfg[dram_readout_pkg::CFG_RL_LSB +: 6];
  wire [1:0] fmt        = (page != 2'h0) ? dram_readout_pkg::FMT_SERIAL : fmt_req;         // RULE_20
  wire       setup      = psel & ~penable;
  wire       wr         = psel & penable & pready & pwrite;
  wire       hit_ctrl   = paddr == dram_readout_pkg::CTRL_OFS;
  wire       hit_cfg    = paddr == dram_readout_pkg::CFG_OFS;
  wire       hit_stat   = paddr == dram_readout_pkg::STAT_OFS;
  wire       hit_data   = paddr == dram_readout_pkg::DATA_OFS;
  wire       mapped     = hit_ctrl | hit_cfg | hit_stat | hit_data;
  wire       go_wr      = wr & hit_ctrl & pwdata[dram_readout_pkg::CTRL_GO_BIT];
  wire       ctrl_go    = go_wr & ~go_pend;
  wire [1:0] wr_op      = pwdata[dram_readout_pkg::CTRL_OP_LSB +: 2];

  // Request decisions
  wire op_enter   = go_op == dram_readout_pkg::OP_ENTER;
  wire op_read    = go_op == dram_readout_pkg::OP_READ;
  wire op_exit    = go_op == dram_readout_pkg::OP_EXIT;
  wire chop_otf   = bc4 & otf;                                                             // RULE_05
  wire enter_ok   = op_enter & (fmt_req != dram_readout_pkg::FMT_RSVD);                    // RULE_12
  wire read_ok    = op_read & ~chop_otf;
  wire read_hold  = read_ok & (ccd_cnt != 6'h00);                                          // RULE_09 RULE_10
  wire exit_hold  = op_exit & (mprr_cnt != 6'h00);                                         // RULE_19
  wire take_idle  = fall_tick & go_pend & (state == dram_readout_pkg::st_idle) & ~(op_enter & dll_hold);
  wire take_mode  = fall_tick & go_pend & (state == dram_readout_pkg::st_in_mode) & ~read_hold & ~exit_hold;
  wire refuse_ev  = (take_idle & ~enter_ok) | (take_mode & ~read_ok & ~op_exit) | (go_wr & go_pend);
  wire idle_like  = (state == dram_readout_pkg::st_idle) | (state == dram_readout_pkg::st_in_mode);
  wire busy       = go_pend | ~idle_like;
  wire cap_on     = state == dram_readout_pkg::st_capture;

  // Address words for each command
  wire [13:0] mr3_keep = (14'(fmt) << dram_readout_pkg::MR3_FMT_LSB)                        // RULE_12
                       | (14'(temp_en) << dram_readout_pkg::MR3_TEMP_BIT) | 14'(page);     // RULE_13
  wire [13:0] mr3_on   = mr3_keep | (14'h0001 << dram_readout_pkg::MR3_EN_BIT);            // RULE_11
  wire [13:0] pre_addr = 14'h0001 << dram_readout_pkg::A10_BIT;
  wire [13:0] rd_addr  = (14'(otf & ~bc4) << dram_readout_pkg::BC_BIT)                     // RULE_15
                       | (14'(nib) << dram_readout_pkg::COL_NIB_BIT);                      // RULE_07 RULE_17
  wire [3:0]  target   = bc4 ? dram_readout_pkg::BEATS_BC4 : dram_readout_pkg::BEATS_BL8;
  wire [2:0]  ui       = beat[2:0] + (nib ? 3'h4 : 3'h0);
  wire [2:0]  bit_idx  = 3'h7 - ui;                                                        // RULE_23
  wire        lanes_eq = (&dq_s) | ~(|dq_s);                                               // RULE_22

  // Command word driven during the next command clock period
  assign next_pins =
    (state == dram_readout_pkg::st_pre)     ? {1'b0, dram_readout_pkg::CMD_PRE, 1'b0, 2'h0, pre_addr} :
    (state == dram_readout_pkg::st_mrs_on)  ? {1'b0, dram_readout_pkg::CMD_MRS, 1'b0, dram_readout_pkg::MR3_BA,
                                               mr3_on} :
    (state == dram_readout_pkg::st_mrs_off) ? {1'b0, dram_readout_pkg::CMD_MRS, 1'b0, dram_readout_pkg::MR3_BA,
                                               mr3_keep} :
    (state == dram_readout_pkg::st_read)    ? {1'b0, dram_readout_pkg::CMD_RD, 1'b0, loc, rd_addr} :  // RULE_14
                                              dram_readout_pkg::PINS_DES;

  // Read multiplexer
  wire [31:0] stat_word = (32'(busy) << dram_readout_pkg::STAT_BUSY) | (32'(mode) << dram_readout_pkg::STAT_MODE)
                        | (32'(done) << dram_readout_pkg::STAT_DONE)
                        | (32'(mismatch) << dram_readout_pkg::STAT_MISMATCH)
                        | (32'(refused) << dram_readout_pkg::STAT_REFUSED)
                        | (32'(timeout) << dram_readout_pkg::STAT_TIMEOUT);
  wire [31:0] rd_mux = hit_ctrl ? {29'h0, go_op, go_pend} :
                       hit_cfg  ? cfg :
                       hit_stat ? stat_word :
                       hit_data ? {24'h0, rd_byte} : 32'h0;

  // Command clock divider, four mclk cycles per half period
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_cnt <= 2'h0;
      ck      <= 1'b0;
    end else begin
      div_cnt <= div_wrap ? 2'h0 : div_cnt + 2'h1;
      if (div_wrap) begin
        ck <= ~ck;
      end
    end
  end

  // APB slave with no wait states; unmapped addresses answer with an error
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
      cfg     <= dram_readout_pkg::CFG_RESET;
    end else begin
      pready  <= setup & ~pready;
      prdata  <= (setup & ~pwrite) ? rd_mux : 32'h0;
      pslverr <= setup & ~mapped;
      if (wr & hit_cfg) begin
        cfg <= pwdata;
      end
    end
  end

  // Sequencer; commands change as the command clock falls
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state     <= dram_readout_pkg::st_idle;
      ret_state <= dram_readout_pkg::st_idle;
      wait_cnt  <= 6'h00;
      ccd_cnt   <= 6'h00;
      mprr_cnt  <= 6'h00;
      go_pend   <= 1'b0;
      go_op     <= 2'h0;
      mode      <= 1'b0;
      pins      <= dram_readout_pkg::PINS_DES;
    end else begin
      if (ctrl_go) begin
        go_pend <= 1'b1;
        go_op   <= wr_op;
      end
      if (take_idle | take_mode) begin
        go_pend <= 1'b0;
      end
      if (fall_tick) begin
        pins <= next_pins;
        if (ccd_cnt != 6'h00) ccd_cnt <= ccd_cnt - 6'h01;
        if (mprr_cnt != 6'h00) mprr_cnt <= mprr_cnt - 6'h01;
        case (state)
          dram_readout_pkg::st_idle: begin
            if (take_idle & enter_ok) state <= dram_readout_pkg::st_pre;                  // RULE_11
          end
          dram_readout_pkg::st_in_mode: begin
            if (take_mode & read_ok) state <= dram_readout_pkg::st_read;
            else if (take_mode & op_exit) state <= dram_readout_pkg::st_mrs_off;         // RULE_19
          end
          dram_readout_pkg::st_pre: begin
            state     <= dram_readout_pkg::st_wait;
            ret_state <= dram_readout_pkg::st_mrs_on;
            wait_cnt  <= 6'(dram_readout_pkg::TRP_CK - 1);                                 // RULE_11
          end
          dram_readout_pkg::st_mrs_on: begin
            mode      <= 1'b1;
            state     <= dram_readout_pkg::st_wait;
            ret_state <= dram_readout_pkg::st_in_mode;
            wait_cnt  <= 6'(dram_readout_pkg::TENTRY_CK - 1);                              // RULE_24
          end
          dram_readout_pkg::st_read: begin
            state     <= dram_readout_pkg::st_wait;
            ret_state <= dram_readout_pkg::st_capture;
            wait_cnt  <= rl - 6'h01;                                                       // RULE_18
            ccd_cnt   <= 6'(dram_readout_pkg::TCCD_L_CK - 1);                              // RULE_10
          end
          dram_readout_pkg::st_mrs_off: begin
            mode      <= 1'b0;
            state     <= dram_readout_pkg::st_wait;
            ret_state <= dram_readout_pkg::st_idle;
            wait_cnt  <= 6'(dram_readout_pkg::TMOD_CK - 1);                                // RULE_19
          end
          dram_readout_pkg::st_wait: begin
            wait_cnt <= wait_cnt - 6'h01;
            if (wait_cnt <= 6'h01) state <= ret_state;
          end
          dram_readout_pkg::st_capture: begin
          end
          default: begin
            state <= dram_readout_pkg::st_idle;
          end
        endcase
      end
      if (cap_on & cap_done) begin
        state    <= dram_readout_pkg::st_in_mode;
        mprr_cnt <= 6'(dram_readout_pkg::READOUT_RECOVERY_TIME_CK);                                        // RULE_19
      end
    end
  end

  // Sticky status; a new accepted request clears, events set and win
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      done     <= 1'b0;
      refused  <= 1'b0;
      timeout  <= 1'b0;
      mismatch <= 1'b0;
    end else begin
      if (ctrl_go) begin
        done     <= 1'b0;
        refused  <= 1'b0;
        timeout  <= 1'b0;
        mismatch <= 1'b0;
      end
      if (refuse_ev) refused <= 1'b1;
      if (cap_on & cap_done) done <= 1'b1;
      if (cap_to) timeout <= 1'b1;
      if (cap_mis) mismatch <= 1'b1;
    end
  end

  // Burst capture: skip the low preamble, sample each strobe edge mid-UI
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dqs_prev  <= 1'b0;
      armed     <= 1'b0;
      beat      <= 4'h0;
      smp_pend  <= 1'b0;
      smp_cnt   <= 2'h0;
      cap_ticks <= 6'h00;
      cap_end   <= 1'b0;
      cap_done  <= 1'b0;
      cap_to    <= 1'b0;
      cap_mis   <= 1'b0;
      rd_byte   <= 8'h00;
    end else begin
      dqs_prev <= dqs_s;
      cap_done <= 1'b0;
      cap_to   <= 1'b0;
      cap_mis  <= 1'b0;
      if (!cap_on) begin
        armed     <= 1'b0;
        beat      <= 4'h0;
        smp_pend  <= 1'b0;
        cap_ticks <= 6'h00;
        cap_end   <= 1'b0;
        if (state == dram_readout_pkg::st_read) rd_byte <= 8'h00;
      end else if (!cap_end) begin
        if (!dqs_s) armed <= 1'b1;                                                         // RULE_21
        if (fall_tick) cap_ticks <= cap_ticks + 6'h01;
        if (dqs_edge & armed) begin
          smp_pend <= 1'b1;
          smp_cnt  <= dram_readout_pkg::SMP_DELAY;
        end else if (smp_pend & (smp_cnt != 2'h0)) begin
          smp_cnt <= smp_cnt - 2'h1;
        end else if (smp_pend) begin
          rd_byte[bit_idx] <= dq_s[0];                                                     // RULE_23
          cap_mis          <= ~lanes_eq;                                                   // RULE_22
          smp_pend         <= 1'b0;
          beat             <= beat + 4'h1;
          if (beat + 4'h1 == target) begin
            cap_end  <= 1'b1;
            cap_done <= 1'b1;
          end
        end
        if (fall_tick & (cap_ticks == 6'(dram_readout_pkg::CAP_LIMIT_CK - 1))) begin
          cap_end  <= 1'b1;
          cap_done <= 1'b1;
          cap_to   <= 1'b1;
        end
      end
    end
  end

  // Helper counters of command clock cycles since commands and since the last burst capture, for the checks
  logic       cs_prev;
  logic [6:0] since_rd;
  logic [6:0] since_mrs;
  logic [6:0] since_cap;
  wire iss     = ~pins.cs_n & cs_prev;
  wire iss_rd  = iss & (pins.code == dram_readout_pkg::CMD_RD);
  wire iss_mrs = iss & (pins.code == dram_readout_pkg::CMD_MRS);
  wire mrs_en  = pins.addr[dram_readout_pkg::MR3_EN_BIT];
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cs_prev   <= 1'b1;
      since_rd  <= 7'h7F;
      since_mrs <= 7'h7F;
      since_cap <= 7'h7F;
    end else begin
      cs_prev   <= pins.cs_n;
      since_rd  <= iss_rd ? 7'h00 : (fall_tick & (since_rd != 7'h7F)) ? since_rd + 7'h01 : since_rd;
      since_mrs <= iss_mrs ? 7'h00 : (fall_tick & (since_mrs != 7'h7F)) ? since_mrs + 7'h01 : since_mrs;
      since_cap <= (cap_on & cap_done) ? 7'h00 : (fall_tick & (since_cap != 7'h7F)) ? since_cap + 7'h01 : since_cap;
    end
  end

  chk_read_low_cols: assert property (@(posedge mclk) disable iff (rst) iss_rd |-> pins.addr[1:0] == 2'h0) // RULE_17
    else $error("readout read with nonzero low column bits");
  chk_burst_order: assert property (@(posedge mclk) disable iff (rst) // RULE_16
    iss_rd |-> pins.addr[dram_readout_pkg::COL_NIB_BIT] == (bc4 & cfg[dram_readout_pkg::CFG_NIB_BIT]))
    else $error("column bit 2 wrong for burst mode");
  chk_chop_select: assert property (@(posedge mclk) disable iff (rst) // RULE_15
    iss_rd && !bc4 && otf |-> pins.addr[dram_readout_pkg::BC_BIT])
    else $error("chop select low on BL8 read with on-the-fly field");
  chk_location_bank: assert property (@(posedge mclk) disable iff (rst) iss_rd |-> pins.ba == loc) // RULE_14
    else $error("read bank bits do not match location");
  chk_entry_fields: assert property (@(posedge mclk) disable iff (rst) // RULE_13
    iss_mrs && mrs_en |-> pins.addr[1:0] == page && pins.ba == dram_readout_pkg::MR3_BA)
    else $error("entry write carries wrong page or register");
  chk_serial_only: assert property (@(posedge mclk) disable iff (rst) // RULE_20
    iss_mrs && page != 2'h0 |-> pins.addr[dram_readout_pkg::MR3_FMT_LSB +: 2] == dram_readout_pkg::FMT_SERIAL)
    else $error("non-serial format for pages 1 to 3");
  chk_read_spacing: assert property (@(posedge mclk) disable iff (rst) // RULE_10
    iss_rd |-> since_rd >= 7'(dram_readout_pkg::TCCD_L_CK))
    else $error("readout reads spaced too closely");
  chk_first_read_gap: assert property (@(posedge mclk) disable iff (rst) // RULE_24
    iss_rd |-> since_mrs >= 7'(dram_readout_pkg::TENTRY_CK))
    else $error("read too soon after mode write");
  chk_exit_recovery: assert property (@(posedge mclk) disable iff (rst) // RULE_19
    iss_mrs && !mrs_en |-> since_cap >= 7'(dram_readout_pkg::READOUT_RECOVERY_TIME_CK))
    else $error("exit write before readout recovery time");
  chk_cmd_hold: assert property (@(posedge mclk) disable iff (rst) // RULE_11
    $fell(pins.cs_n) |-> !pins.cs_n [*8] ##1 pins.cs_n)
    else $error("command not held for one command clock");

endmodule

// >>> shared/dram_readout_pkg.sv
package dram_readout_pkg;

  // Register offsets of the controller's own APB registers
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CFG_OFS  = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] DATA_OFS = 8'h0C;

  // Control word fields
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_OP_LSB = 1;

  // Operation codes
  localparam logic [1:0] OP_ENTER = 2'h0;
  localparam logic [1:0] OP_READ  = 2'h1;
  localparam logic [1:0] OP_EXIT  = 2'h2;

  // Configuration word fields and reset value
  localparam int          CFG_PAGE_LSB = 0;
  localparam int          CFG_LOC_LSB  = 2;
  localparam int          CFG_FMT_LSB  = 4;
  localparam int          CFG_BC4_BIT  = 6;
  localparam int          CFG_NIB_BIT  = 7;
  localparam int          CFG_TEMP_BIT = 8;
  localparam int          CFG_OTF_BIT  = 9;
  localparam int          CFG_DLL_BIT  = 10;
  localparam int          CFG_RL_LSB   = 11;
  localparam logic [31:0] CFG_RESET    = 32'h0000_8000;

  // Status word fields
  localparam int STAT_BUSY     = 0;
  localparam int STAT_MODE     = 1;
  localparam int STAT_DONE     = 2;
  localparam int STAT_MISMATCH = 3;
  localparam int STAT_REFUSED  = 4;
  localparam int STAT_TIMEOUT  = 5;

  // Address bit positions used on the command/address bus
  localparam logic [1:0] MR3_BA       = 2'h3;
  localparam int         MR3_EN_BIT   = 2;
  localparam int         MR3_TEMP_BIT = 5;
  localparam int         MR3_FMT_LSB  = 11;
  localparam int         A10_BIT      = 10;
  localparam int         BC_BIT       = 12;
  localparam int         COL_NIB_BIT  = 2;
  localparam logic [1:0] FMT_SERIAL   = 2'h0;
  localparam logic [1:0] FMT_RSVD     = 2'h3;

  // Command codes as {act_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h8;
  localparam logic [3:0] CMD_PRE = 4'hA;
  localparam logic [3:0] CMD_RD  = 4'hD;

  // Timing counts, in command clock cycles; DIV_LAST and SMP_DELAY in mclk cycles, BEATS_BL8 and BEATS_BC4 in data beats
  localparam logic [1:0] DIV_LAST     = 2'h3;
  localparam int         TRP_CK       = 6;
  localparam int         TMRD_CK      = 8;
  localparam int         TMOD_CK      = 24;
  localparam int         TENTRY_CK    = (TMOD_CK > TMRD_CK) ? TMOD_CK : TMRD_CK;
  localparam int         TCCD_L_CK    = 6;
  localparam int         READOUT_RECOVERY_TIME_CK     = 2;
  localparam int         CAP_LIMIT_CK = 16;
  localparam logic [1:0] SMP_DELAY    = 2'h1;
  localparam logic [3:0] BEATS_BL8    = 4'h8;
  localparam logic [3:0] BEATS_BC4    = 4'h4;

  typedef enum logic [7:0] {
    st_idle    = 8'h01,
    st_pre     = 8'h02,
    st_mrs_on  = 8'h04,
    st_in_mode = 8'h08,
    st_read    = 8'h10,
    st_wait    = 8'h20,
    st_capture = 8'h40,
    st_mrs_off = 8'h80
  } state_t;

  typedef struct packed {
    logic        cs_n;
    logic [3:0]  code;
    logic        bg0;
    logic [1:0]  ba;
    logic [13:0] addr;
  } cmd_pins_t;

  localparam cmd_pins_t PINS_DES = '{cs_n: 1'b1, code: 4'hF, bg0: 1'b0, ba: 2'h0, addr: 14'h0000};

endpackage
